// file: rtl/terminal_regs_pkg.sv
// Constants shared by the terminal register structure and its coupler.
// Assumes one 20 MHz clock and a synchronous active-high reset.
//
// How it works
// RQ1 - Each channel owns sixty-four word registers
// RQ2 - Areas: process, type, maker, user, extended
// RQ3 - One independent register set per logical channel
// RQ4 - Process variables live in terminal RAM
// RQ5 - First six process words are type-specific
// RQ6 - Diagnostic word flags extra faults, e.g. parity
// RQ7 - Coupler writes number low, argument high
// RQ8 - Command read gives result high, number low
// RQ9 - Type words fixed, readable, never writable
// RQ10 - Terminal kind word identifies the terminal
// RQ11 - Firmware version reads as ASCII text
// RQ12 - Data length: shift register count, bit length
// RQ13 - Logical channel count, may exceed registers
// RQ14 - Minimum bytes to transfer, status excluded
// RQ15 - Coupler maps the control/status byte too
// RQ16 - Control/status byte sits in the low byte; the code puts it in byte 3, bits 31:24
// RQ17 - Image is six bytes each way
// RQ18 - Writes to type words are silently dropped
`default_nettype none
package terminal_regs_pkg;
    // -----------------------------------------------------------------
    // Register map of one channel (word addresses)
    // -----------------------------------------------------------------
    localparam int         REG_COUNT   = 64;
    localparam logic [5:0] PV_LAST     = 6'h07;
    localparam logic [5:0] DIAG_ADDR   = 6'h06;
    localparam logic [5:0] CMD_ADDR    = 6'h07;
    localparam logic [5:0] KIND_ADDR   = 6'h08;
    localparam logic [5:0] FW_ADDR     = 6'h09;
    localparam logic [5:0] SHLEN_ADDR  = 6'h0a;
    localparam logic [5:0] LCH_ADDR    = 6'h0b;
    localparam logic [5:0] MINLEN_ADDR = 6'h0c;
    localparam logic [5:0] TYPE_LAST   = 6'h0f;
    localparam logic [5:0] MFR_BASE    = 6'h10;
    localparam logic [5:0] USER_BASE   = 6'h20;
    localparam logic [5:0] EXT_BASE    = 6'h30;

    // -----------------------------------------------------------------
    // Process image layout
    // -----------------------------------------------------------------
    localparam int IMAGE_BYTES = 6;
    localparam int DATA_BYTES  = 3;
    localparam int CTL_BYTE    = 3;
    localparam int REQ_BIT     = 7;
    localparam int WR_BIT      = 6;

    // -----------------------------------------------------------------
    // Coupler APB registers (byte offsets) and timing
    // -----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] WDATA_OFS  = 8'h04;
    localparam logic [7:0] RDATA_OFS  = 8'h08;
    localparam logic [7:0] STAT_OFS   = 8'h0c;
    localparam logic [7:0] ISTAT_OFS  = 8'h10;
    localparam logic [7:0] IMASK_OFS  = 8'h14;
    localparam logic [7:0] OUTD_OFS   = 8'h18;
    localparam logic [7:0] IND_OFS    = 8'h1c;
    localparam int         EV_DONE    = 0;
    localparam int         EV_CYCLE   = 1;
    localparam int         EXCH_TICKS = 16;

    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_SEND = 2'b01,
        C_WAIT = 2'b11
    } cycle_state_e;
endpackage
`default_nettype wire

// file: rtl/terminal_link_if.sv
// Process image link between coupler and terminal.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface terminal_link_if #(parameter int CH_W = 2);
    logic [47:0]     out_image;
    logic            out_strobe;
    logic [CH_W-1:0] out_chan;
    logic [47:0]     in_image;
    logic            in_strobe;

    modport coupler  (output out_image, out_strobe, out_chan, input in_image, in_strobe);
    modport terminal (input out_image, out_strobe, out_chan, output in_image, in_strobe);
endinterface
`default_nettype wire

// file: rtl/terminal_register_structure.sv
// Word-organised register structure of an intelligent I/O terminal.
// Assumes the coupler presents one output image per exchange strobe.
`timescale 1ns/1ps
`default_nettype none
module terminal_register_structure import terminal_regs_pkg::*; #(
    parameter int          NUM_CH    = 4,
    parameter int          CH_W      = 2,
    parameter logic [15:0] KIND      = 16'h0001, // Arbitrary value
    parameter logic [7:0]  FW_MAJOR  = 8'h31,
    parameter logic [7:0]  FW_MINOR  = 8'h61,
    parameter logic [7:0]  SHIFT_CNT = 8'h01,
    parameter logic [7:0]  SHIFT_LEN = 8'h30,
    parameter logic [7:0]  MIN_IN    = 8'h03,
    parameter logic [7:0]  MIN_OUT   = 8'h03
) (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    // Process image link
    terminal_link_if.terminal         link,
    // Cyclic process data
    input  wire logic [NUM_CH*24-1:0] pd_in,
    output logic      [23:0]          pd_out,
    output logic      [CH_W-1:0]      pd_chan_out,
    output logic                      pd_valid_out,
    // Diagnostic events
    input  wire logic [NUM_CH*16-1:0] diag_set_in,
    // Function calls
    output logic                      func_valid_out,
    output logic      [CH_W-1:0]      func_chan_out,
    output logic      [7:0]           func_num_out,
    output logic      [7:0]           func_param_out,
    input  wire logic                 func_done_in,
    input  wire logic [7:0]           func_result_in
);
    // -----------------------------------------------------------------
    // Decoding
    // -----------------------------------------------------------------
    function automatic logic is_type_word(input logic [5:0] a);
        return (a >= KIND_ADDR) && (a <= TYPE_LAST);
    endfunction

    function automatic logic is_ram_word(input logic [5:0] a);
        return (a < DIAG_ADDR) || (a >= MFR_BASE);
    endfunction

    localparam int MEM_WORDS = (1 << CH_W) * REG_COUNT;

    logic [15:0] mem [MEM_WORDS]; // RQ1 RQ3 RQ4
    logic [15:0] diag [NUM_CH];
    logic [7:0]  fnum [NUM_CH];
    logic [7:0]  fres [NUM_CH];
    logic [NUM_CH-1:0] ack;

    wire logic [CH_W-1:0]   chan    = link.out_chan;
    wire logic [7:0]        ctl     = link.out_image[CTL_BYTE*8 +: 8]; // RQ16
    wire logic [15:0]       wdata   = link.out_image[47:32]; // RQ17
    wire logic              req     = ctl[REQ_BIT];
    wire logic              wr      = ctl[WR_BIT];
    wire logic [5:0]        addr    = ctl[5:0];
    wire logic              chan_ok = 32'(chan) < NUM_CH;
    wire logic [CH_W+5:0]   midx    = {chan, addr};
    wire logic              ack_cur = chan_ok ? ack[chan] : 1'b1;
    wire logic              new_acc = link.out_strobe && req && !ack_cur && chan_ok;
    wire logic              wr_acc  = new_acc && wr;
    wire logic              rd_diag = new_acc && !wr && (addr == DIAG_ADDR);
    wire logic              wr_ram  = wr_acc && is_ram_word(addr); // RQ18
    wire logic              wr_cmd  = wr_acc && (addr == CMD_ADDR);
    wire logic [23:0]       pd_sel  = chan_ok ? pd_in[chan*24 +: 24] : 24'h000000;

    // -----------------------------------------------------------------
    // Fixed type words
    // -----------------------------------------------------------------
    logic [15:0] type_word;
    always_comb begin
        case (addr)
            KIND_ADDR:   type_word = KIND; // RQ9 RQ10
            FW_ADDR:     type_word = {FW_MAJOR, FW_MINOR}; // RQ11
            SHLEN_ADDR:  type_word = {SHIFT_CNT, SHIFT_LEN}; // RQ12
            LCH_ADDR:    type_word = 16'(NUM_CH); // RQ13
            MINLEN_ADDR: type_word = {MIN_OUT, MIN_IN}; // RQ14
            default:     type_word = 16'h0000;
        endcase
    end

    // -----------------------------------------------------------------
    // Read selection
    // -----------------------------------------------------------------
    logic [15:0] rd_word;
    always_comb begin
        if (!chan_ok) begin
            rd_word = 16'h0000;
        end else if (addr == DIAG_ADDR) begin
            rd_word = diag[chan]; // RQ6
        end else if (addr == CMD_ADDR) begin
            rd_word = {fres[chan], fnum[chan]}; // RQ8
        end else if (is_type_word(addr)) begin
            rd_word = type_word; // RQ9
        end else begin
            rd_word = mem[midx]; // RQ2 RQ5
        end
    end

    // Status echo carries the request back so the coupler can match it
    wire logic [7:0]  status  = (req && chan_ok) ? ctl : 8'h00;
    wire logic [47:0] next_in = {rd_word, status, pd_sel}; // RQ17

    // -----------------------------------------------------------------
    // Register RAM, no reset: contents are parameters, not control
    // -----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (wr_ram) begin
            mem[midx] <= wdata; // RQ1 RQ4
        end
    end

    // -----------------------------------------------------------------
    // Per-channel handshake, diagnostics and command words
    // -----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            wire logic hit = chan_ok && (32'(chan) == g);
            wire logic [15:0] next_diag =
                (diag[g] & ((rd_diag && hit) ? 16'h0000 : 16'hffff))
                | diag_set_in[g*16 +: 16];

            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    ack[g]  <= 1'b0;
                    diag[g] <= 16'h0000;
                    fnum[g] <= 8'h00;
                    fres[g] <= 8'h00;
                end else begin
                    if (link.out_strobe && hit) begin
                        ack[g] <= req;
                    end
                    // Set wins over clear-on-read
                    diag[g] <= next_diag; // RQ6
                    if (wr_cmd && hit) begin
                        fnum[g] <= wdata[7:0]; // RQ7
                        fres[g] <= 8'h00;
                    end else if (func_done_in && (32'(func_chan_out) == g)) begin
                        fres[g] <= func_result_in; // RQ8
                    end
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Answer image and user-side outputs
    // -----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            link.in_image  <= 48'h000000000000;
            link.in_strobe <= 1'b0;
            pd_out         <= 24'h000000;
            pd_chan_out    <= '0;
            pd_valid_out   <= 1'b0;
            func_valid_out <= 1'b0;
            func_chan_out  <= '0;
            func_num_out   <= 8'h00;
            func_param_out <= 8'h00;
        end else begin
            link.in_strobe <= link.out_strobe;
            pd_valid_out   <= link.out_strobe && chan_ok;
            func_valid_out <= wr_cmd;
            if (link.out_strobe) begin
                link.in_image <= next_in; // RQ16 RQ17
                pd_out        <= link.out_image[DATA_BYTES*8-1:0];
                pd_chan_out   <= chan;
            end
            if (wr_cmd) begin
                func_chan_out  <= chan;
                func_num_out   <= wdata[7:0]; // RQ7
                func_param_out <= wdata[15:8];
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/terminal_coupler.sv
// Coupler end: APB registers drive cyclic image exchanges.
// Assumes a terminal answers each exchange strobe on the link.
`timescale 1ns/1ps
`default_nettype none
module terminal_coupler import terminal_regs_pkg::*; #(
    parameter int CH_W       = 2,
    parameter int EXCH_CYCLE = EXCH_TICKS
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             irq_out,
    // Process image link
    terminal_link_if.coupler link
);
    // -----------------------------------------------------------------
    // Software registers
    // -----------------------------------------------------------------
    logic [CH_W-1:0] chan;
    logic            wr_mode;
    logic [5:0]      addr;
    logic [15:0]     wdata;
    logic [15:0]     rdata;
    logic            pending;
    logic            release_req;
    logic [1:0]      istat;
    logic [1:0]      imask;
    logic [23:0]     out_data;
    logic [23:0]     in_data;
    logic [7:0]      tick_cnt;
    cycle_state_e    state;

    wire logic setup    = psel_in && !penable_in;
    wire logic wr_acc   = psel_in && penable_in && pready_out && pwrite_in;
    wire logic wr_ctrl  = wr_acc && (paddr_in == CTRL_OFS);
    wire logic start    = wr_ctrl && pwdata_in[0] && !pending && !release_req;
    wire logic tick     = tick_cnt == 8'(EXCH_CYCLE - 1);
    wire logic [7:0] st = link.in_image[CTL_BYTE*8 +: 8];
    wire logic match    = pending && st[REQ_BIT] && (st[5:0] == addr);
    wire logic answer   = (state == C_WAIT) && link.in_strobe;
    wire logic [1:0] ev = {answer, answer && match};
    wire logic [1:0] w1c =
        (wr_acc && (paddr_in == ISTAT_OFS)) ? pwdata_in[1:0] : 2'b00;

    logic [31:0] rd_mux;
    logic        unmapped;
    always_comb begin
        unmapped = 1'b0;
        case (paddr_in)
            CTRL_OFS:  rd_mux = {14'h0000, 2'(chan), 2'b00, addr, 6'h00, wr_mode, 1'b0};
            WDATA_OFS: rd_mux = {16'h0000, wdata};
            RDATA_OFS: rd_mux = {16'h0000, rdata};
            STAT_OFS:  rd_mux = {31'h00000000, pending || release_req};
            ISTAT_OFS: rd_mux = {30'h00000000, istat};
            IMASK_OFS: rd_mux = {30'h00000000, imask};
            OUTD_OFS:  rd_mux = {8'h00, out_data};
            IND_OFS:   rd_mux = {8'h00, in_data};
            default: begin
                rd_mux   = 32'h00000000;
                unmapped = 1'b1;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // APB and interrupt
    // -----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h00000000;
            chan        <= '0;
            wr_mode     <= 1'b0;
            addr        <= 6'h00;
            wdata       <= 16'h0000;
            imask       <= 2'b00;
            out_data    <= 24'h000000;
            istat       <= 2'b00;
            irq_out     <= 1'b0;
        end else begin
            pready_out  <= setup;
            pslverr_out <= setup && unmapped;
            prdata_out  <= setup ? rd_mux : 32'h00000000;
            // Address fields frozen while a register access is open
            if (wr_ctrl && !pending && !release_req) begin
                chan    <= pwdata_in[CH_W+15:16];
                addr    <= pwdata_in[13:8];
                wr_mode <= pwdata_in[1];
            end
            if (wr_acc && (paddr_in == WDATA_OFS) && !pending) begin
                wdata <= pwdata_in[15:0];
            end
            if (wr_acc && (paddr_in == IMASK_OFS)) begin
                imask <= pwdata_in[1:0];
            end
            if (wr_acc && (paddr_in == OUTD_OFS)) begin
                out_data <= pwdata_in[23:0];
            end
            istat   <= (istat & ~w1c) | ev;
            irq_out <= |(((istat & ~w1c) | ev) & imask);
        end
    end

    // -----------------------------------------------------------------
    // Exchange sequencer
    // -----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state           <= C_IDLE;
            tick_cnt        <= 8'h00;
            pending         <= 1'b0;
            release_req     <= 1'b0;
            rdata           <= 16'h0000;
            in_data         <= 24'h000000;
            link.out_image  <= 48'h000000000000;
            link.out_strobe <= 1'b0;
            link.out_chan   <= '0;
        end else begin
            tick_cnt        <= tick ? 8'h00 : tick_cnt + 8'h01;
            link.out_strobe <= 1'b0;
            if (start) begin
                pending <= 1'b1;
            end
            case (state)
                C_IDLE: begin
                    if (tick) begin
                        state           <= C_SEND;
                        link.out_strobe <= 1'b1;
                        link.out_chan   <= chan;
                        // Request bit dropped once to free the terminal
                        link.out_image  <= {wdata, pending, wr_mode, addr,
                                            out_data}; // RQ15 RQ16 RQ17 RQ7
                    end
                end
                C_SEND: state <= C_WAIT;
                C_WAIT: begin
                    if (link.in_strobe) begin
                        state   <= C_IDLE;
                        in_data <= link.in_image[23:0];
                        if (release_req && !link.out_image[CTL_BYTE*8+REQ_BIT]) begin
                            release_req <= 1'b0;
                        end
                        if (match) begin
                            rdata       <= link.in_image[47:32];
                            pending     <= 1'b0;
                            release_req <= 1'b1;
                        end
                    end
                end
                default: state <= C_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: test/terminal_link_chk.sv
// Assertions on the process image link between coupler and terminal.
// Assumes one clock; instantiated beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module terminal_link_chk #(
    parameter int          CH_W   = 2,
    parameter int          NUM_CH = 4,
    parameter logic [15:0] KIND   = 16'h0001, // Arbitrary value
    parameter logic [15:0] FW     = 16'h3161
) (
    input wire logic            clk_in,
    input wire logic            rst_in,
    input wire logic [47:0]     out_image,
    input wire logic            out_strobe,
    input wire logic [CH_W-1:0] out_chan,
    input wire logic [47:0]     in_image,
    input wire logic            in_strobe
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // -----------------------------------------------------------------
    // Exchange steps
    // -----------------------------------------------------------------
    sequence req_s;
        out_strobe && out_image[31] && (out_chan < NUM_CH);
    endsequence
    sequence addr_s(logic [5:0] a);
        req_s ##0 (out_image[29:24] == a);
    endsequence
    property word_p(logic [5:0] a, logic [15:0] v);
        addr_s(a) |=> (in_image[47:32] == v);
    endproperty
    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    answer_next_a: assert property (out_strobe |=> in_strobe)
        else $error("no answer one cycle after exchange strobe");
    answer_cause_a: assert property (in_strobe |-> $past(out_strobe))
        else $error("answer strobe without exchange");
    strobe_gap_a: assert property (out_strobe |=> !out_strobe [*2])
        else $error("exchange strobes too close");
    image_hold_a: assert property (!in_strobe |-> $stable(in_image))
        else $error("input image changed between answers");
    status_echo_a: assert property (req_s |=> (in_image[31:24] == $past(out_image[31:24])))
        else $error("status byte does not echo control byte");
    status_idle_a: assert property ((out_strobe && !out_image[31]) |=> in_image[31:24] == 8'h00)
        else $error("status byte not zero without request");
    kind_fixed_a: assert property (word_p(6'h08, KIND))
        else $error("terminal kind word wrong");
    fw_ascii_a: assert property (word_p(6'h09, FW))
        else $error("firmware word wrong");
    chan_count_a: assert property (word_p(6'h0b, 16'(NUM_CH)))
        else $error("channel count word wrong");
endmodule
`default_nettype wire

// file: test/test_terminal_register_structure.sv
// Bench for coupler and terminal joined by the link interface.
// Assumes APB software access only; function unit modelled here.
`timescale 1ns/1ps
`default_nettype none
module test_terminal_register_structure import terminal_regs_pkg::*; ;
    localparam int          NCH  = 3;
    localparam int          EXCH = 4;
    localparam logic [15:0] KIND = 16'h0001; // Arbitrary value
    localparam logic [15:0] FW   = 16'h3161;
    logic        clk_in, rst_in, psel, penable, pwrite, pready, pslverr, irq, serr;
    logic        pd_valid, fv, fdone;
    logic [7:0]  paddr, fnum, fpar, fres, cnum, cpar;
    logic [1:0]  pd_chan, fch, cch;
    logic [31:0] pwdata, prdata, q;
    logic [71:0] pd_in;
    logic [47:0] diag;
    logic [23:0] pd_out, pd_seen, v24;
    logic [15:0] rnd, rd, v;
    logic [15:0] mem [NCH][8];
    logic [5:0]  ram_a [8] = '{6'h00, 6'h05, 6'h10, 6'h1f, 6'h20, 6'h2f, 6'h30, 6'h3f};
    int          failures, n_compared, cyc;

    terminal_link_if #(.CH_W(2)) terminal_link_if_i ();
    terminal_register_structure #(.NUM_CH(NCH), .CH_W(2)) terminal_register_structure_i (
        .clk_in(clk_in), .rst_in(rst_in), .link(terminal_link_if_i), .pd_in(pd_in),
        .pd_out(pd_out), .pd_chan_out(pd_chan), .pd_valid_out(pd_valid), .diag_set_in(diag),
        .func_valid_out(fv), .func_chan_out(fch), .func_num_out(fnum),
        .func_param_out(fpar), .func_done_in(fdone), .func_result_in(fres));
    terminal_coupler #(.CH_W(2), .EXCH_CYCLE(EXCH)) terminal_coupler_i (
        .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq), .link(terminal_link_if_i));
    terminal_link_chk #(.CH_W(2), .NUM_CH(NCH), .KIND(KIND), .FW(FW)) terminal_link_chk_i (
        .clk_in(clk_in), .rst_in(rst_in), .out_image(terminal_link_if_i.out_image),
        .out_strobe(terminal_link_if_i.out_strobe), .out_chan(terminal_link_if_i.out_chan),
        .in_image(terminal_link_if_i.in_image), .in_strobe(terminal_link_if_i.in_strobe));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // -----------------------------------------------------------------
    // Function unit and monitors
    // -----------------------------------------------------------------
    always @(posedge clk_in) begin
        fdone <= fv;
        if (fv === 1'b1) begin
            cnum <= fnum;
            cpar <= fpar;
            cch  <= fch;
            fres <= fpar ^ 8'h5a;
        end
        if (pd_valid === 1'b1) pd_seen <= pd_out;
        cyc <= cyc + 1;
        // Generous: the full run needs about two thousand cycles
        if (cyc == 30000) begin
            failures = failures + 1;
            tally_and_finish();
        end
    end

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [15:0] nxt();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        return rnd;
    endfunction
    function automatic logic [15:0] type_word(input logic [5:0] a);
        case (a)
            KIND_ADDR:   return KIND;
            FW_ADDR:     return FW;
            SHLEN_ADDR:  return 16'h0130;
            LCH_ADDR:    return 16'(NCH);
            MINLEN_ADDR: return 16'h0303;
            default:     return 16'h0000;
        endcase
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        q = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    // One register access over the link; busy holds until the release exchange
    task automatic ra(input logic [1:0] ch, input logic w, input logic [5:0] a,
                      input logic [15:0] wd);
        apb(1'b1, WDATA_OFS, {16'h0000, wd});
        apb(1'b1, CTRL_OFS, {14'h0000, ch, 2'b00, a, 6'h00, w, 1'b1});
        q = 32'h1;
        while (q[0] !== 1'b0) apb(1'b0, STAT_OFS, 32'h0);
        apb(1'b0, RDATA_OFS, 32'h0);
        rd = q[15:0];
    endtask
    task automatic tally_and_finish();
        $display("compared %0d failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, fdone, rst_in} = 5'b00001;
        {paddr, pwdata, fres, diag} = '0;
        {failures, n_compared, cyc} = '0;
        rnd = 16'h005a;
        for (int i = 0; i < NCH; i++) pd_in[i*24+:24] = 24'({nxt(), nxt()});
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        apb(1'b1, IMASK_OFS, 32'h1);
        for (int c = 0; c < NCH; c++) begin
            for (int a = 8; a < 16; a++) begin
                ra(2'(c), 1'b1, 6'(a), nxt());
                chk(rd, type_word(6'(a)));
                ra(2'(c), 1'b0, 6'(a), 16'h0000);
                chk(rd, type_word(6'(a)));
            end
        end
        chk(irq, 1'b1);
        apb(1'b0, ISTAT_OFS, 32'h0);
        chk(q[0], 1'b1);
        apb(1'b1, ISTAT_OFS, 32'h1);
        chk(irq, 1'b0);
        // All channels written before any read back, so crosstalk shows
        for (int c = 0; c < NCH; c++) begin
            for (int i = 0; i < 8; i++) begin
                mem[c][i] = nxt();
                ra(2'(c), 1'b1, ram_a[i], mem[c][i]);
            end
        end
        for (int c = 0; c < NCH; c++) begin
            for (int i = 0; i < 8; i++) begin
                ra(2'(c), 1'b0, ram_a[i], 16'h0000);
                chk(rd, mem[c][i]);
            end
        end
        v = nxt() | 16'h8001;
        diag[16+:16] <= v;
        @(posedge clk_in);
        diag <= '0;
        ra(2'd1, 1'b0, DIAG_ADDR, 16'h0000);
        chk(rd, v);
        ra(2'd1, 1'b0, DIAG_ADDR, 16'h0000);
        chk(rd, 16'h0000);
        ra(2'd0, 1'b0, DIAG_ADDR, 16'h0000);
        chk(rd, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? 16'hff00 : nxt();
            ra(2'd2, 1'b1, CMD_ADDR, v);
            chk({cch, cpar, cnum}, {2'd2, v});
            ra(2'd2, 1'b0, CMD_ADDR, 16'h0000);
            chk(rd, {v[15:8] ^ 8'h5a, v[7:0]});
        end
        ra(2'd1, 1'b0, KIND_ADDR, 16'h0000);
        chk(rd, KIND);
        v24 = 24'({nxt(), nxt()});
        apb(1'b1, OUTD_OFS, {8'h00, v24});
        repeat (3 * EXCH) @(posedge clk_in);
        chk(pd_seen, v24);
        chk(pd_chan, 2'd1);
        apb(1'b0, IND_OFS, 32'h0);
        chk(q, {8'h00, pd_in[24+:24]});
        apb(1'b0, 8'h20, 32'h0);
        chk(serr, 1'b1);
        chk(q, 32'h00000000);
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        ra(2'd0, 1'b0, FW_ADDR, 16'h0000);
        chk(rd, FW);
        tally_and_finish();
    end
endmodule
`default_nettype wire
